// File: logic/flash_lock_pkg.sv
`default_nettype none
package flash_lock_pkg;
	// register byte addresses (each register one aligned word)
	localparam logic [11:0] ADDR_LOCK_CONFIG  = 12'h004;
	localparam logic [11:0] ADDR_FACTORY_TEST = 12'h008;
	localparam logic [11:0] ADDR_IRQ_KEY_GATE = 12'h00C;
	localparam logic [11:0] ADDR_PROTECT      = 12'h010;
	// lock configuration fields
	localparam int BACKDOOR_EN_HI = 7;
	localparam int BACKDOOR_EN_LO = 6;
	localparam int LOCK_STATE_HI  = 1;
	localparam int LOCK_STATE_LO  = 0;
	localparam logic [1:0] BACKDOOR_ENABLED = 2'h2;
	localparam logic [1:0] LOCK_UNLOCKED    = 2'h2;
	localparam logic [7:0] USER_FLAGS_MASK  = 8'h3C;
	// irq / key gate fields
	localparam int BUF_EMPTY_IE_BIT = 7;
	localparam int CMD_DONE_IE_BIT  = 6;
	localparam int KEY_GATE_BIT     = 5;
	localparam logic [7:0] IRQ_KEY_GATE_RESET = 8'h00;
	// protect fields
	localparam int POLARITY_BIT   = 7;
	localparam int HIGH_DIS_BIT   = 5;
	localparam int HIGH_SIZE_HI   = 4;
	localparam int HIGH_SIZE_LO   = 3;
	localparam int LOW_DIS_BIT    = 2;
	localparam int LOW_SIZE_HI    = 1;
	localparam int LOW_SIZE_LO    = 0;
	// reset-load source locations in the flash array
	localparam logic [15:0] LOCK_LOAD_ADDR    = 16'hFF0F;
	localparam logic [15:0] PROTECT_LOAD_ADDR = 16'hFF0D;
	// protected range geometry
	localparam logic [15:0] HIGH_RANGE_END = 16'hFFFF;
	localparam logic [15:0] LOW_RANGE_BASE = 16'h4000;
	localparam logic [15:0] HIGH_START_0 = 16'hF800;
	localparam logic [15:0] HIGH_START_1 = 16'hF000;
	localparam logic [15:0] HIGH_START_2 = 16'hE000;
	localparam logic [15:0] HIGH_START_3 = 16'hC000;
	localparam logic [15:0] LOW_END_0 = 16'h43FF;
	localparam logic [15:0] LOW_END_1 = 16'h47FF;
	localparam logic [15:0] LOW_END_2 = 16'h4FFF;
	localparam logic [15:0] LOW_END_3 = 16'h5FFF;
	// reset loader sequence
	typedef enum logic [1:0] {LD_LOCK, LD_PROT, LD_DONE} load_state_e;
endpackage
`default_nettype wire

// File: logic/flash_lock_and_protect_regs.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module flash_lock_and_protect_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             nvm_rd_req,
	output logic      [15:0] nvm_rd_addr,
	input  wire logic [7:0]  nvm_rd_data,
	input  wire logic        nvm_rd_valid,
	output logic             load_done,
	input  wire logic        backdoor_unlock,
	input  wire logic        buffer_empty_flag,
	input  wire logic        cmd_done_flag,
	output logic             flash_irq,
	output logic             unlocked,
	output logic             backdoor_allowed,
	output logic             key_write_gate,
	output logic             array_read_invalid,
	input  wire logic        op_req,
	input  wire logic        op_mass_erase,
	input  wire logic [15:0] op_addr,
	output logic             op_grant,
	output logic             protect_violation_flag
);
	import flash_lock_pkg::*;

	logic [7:0]  lock_config_reg;
	logic [7:0]  irq_key_gate_reg;
	logic [7:0]  irq_key_gate_next;
	logic [7:0]  protect_reg;
	logic [7:0]  protect_next;
	logic [31:0] prdata_next;
	load_state_e load_state_reg;

	// bus decode: single-cycle slave, every access finishes in its
	// access phase; pready is tied high because every register is a
	// plain flop and the read mux settles well inside one cycle, so
	// a wait state would only cost bus time for nothing
	// only byte lane 0 carries register bits; the upper lanes of
	// pwdata are ignored and read back as zero
	wire acc        = psel & penable;
	wire wr_en      = acc & pwrite & pstrb[0];
	wire hit_lock   = (paddr == ADDR_LOCK_CONFIG);
	wire hit_test   = (paddr == ADDR_FACTORY_TEST);
	wire hit_gate   = (paddr == ADDR_IRQ_KEY_GATE);
	wire hit_prot   = (paddr == ADDR_PROTECT);
	wire hit_any    = hit_lock | hit_test | hit_gate | hit_prot;
	wire [7:0] wb   = pwdata[7:0];
	assign pready   = 1'b1;
	assign pslverr  = acc & ~hit_any;

	// per-register write strobes; none fire while the reset load runs,
	// so a write racing the loader can never be half overwritten
	wire wr_gate    = wr_en & hit_gate & load_done;
	wire wr_prot    = wr_en & hit_prot & load_done;

	// reset loader: registers stay inert until both bytes arrived;
	// the lock byte comes first so security is settled before the
	// protection byte, and the request stays up until the array
	// answers, however slowly it does so
	wire loading    = (load_state_reg != LD_DONE);
	assign load_done   = ~loading;
	assign nvm_rd_req  = loading;
	assign nvm_rd_addr = (load_state_reg == LD_LOCK) ? LOCK_LOAD_ADDR
		: PROTECT_LOAD_ADDR;

	// lock decode: only the code 10 opens either door; every other
	// code, an erased or half-programmed byte too, keeps the part
	// locked and the backdoor shut, and both stay low until the
	// byte has actually been loaded
	wire [1:0] bd_code   = lock_config_reg[BACKDOOR_EN_HI:BACKDOOR_EN_LO];
	wire [1:0] lock_code = lock_config_reg[LOCK_STATE_HI:LOCK_STATE_LO];
	assign backdoor_allowed = load_done & (bd_code == BACKDOOR_ENABLED);
	assign unlocked         = load_done & (lock_code == LOCK_UNLOCKED);
	// user flag bits 5-2 only travel to the read path

	// control register write: reserved bits forced zero; the key gate
	// bit keeps its value on a write while the backdoor is shut, the
	// two enables beside it still take the written value
	wire       gate_ok  = backdoor_allowed;
	wire [7:0] gate_old = irq_key_gate_reg;
	always_comb begin
		irq_key_gate_next = gate_old;
		if (wr_gate) begin
			irq_key_gate_next[BUF_EMPTY_IE_BIT] = wb[BUF_EMPTY_IE_BIT];
			irq_key_gate_next[CMD_DONE_IE_BIT]  = wb[CMD_DONE_IE_BIT];
			if (gate_ok)
				irq_key_gate_next[KEY_GATE_BIT] = wb[KEY_GATE_BIT];
		end
	end

	// interrupt request, straight from enables and flags; no latch
	// here, so the line drops as soon as the status logic clears the
	// flag, and the request cannot outlive its cause
	wire irq_be = irq_key_gate_reg[BUF_EMPTY_IE_BIT] & buffer_empty_flag;
	wire irq_cd = irq_key_gate_reg[CMD_DONE_IE_BIT] & cmd_done_flag;
	assign flash_irq = irq_be | irq_cd;

	// key gate: sequencer diverts array writes, array reads marked bad;
	// both views come from the same flop so they can never disagree
	assign key_write_gate     = irq_key_gate_reg[KEY_GATE_BIT];
	assign array_read_invalid = irq_key_gate_reg[KEY_GATE_BIT];

	// protection scenario: polarity, high disable, low disable
	function automatic logic [2:0] scen(input logic [7:0] p);
		scen = {p[POLARITY_BIT], p[HIGH_DIS_BIT], p[LOW_DIS_BIT]};
	endfunction

	// a write is legal only if it keeps or adds protection, read from
	// {polarity, high disable, low disable}: with polarity set a
	// disable bit may only be cleared, which arms one more range;
	// with polarity clear it may only be set, which closes an open
	// range; the polarity bit never moves in a legal write, since the
	// open-polarity group can expose ranges the old scenario covered
	function automatic logic scen_ok(input logic [2:0] f, input logic [2:0] t);
		logic ok;
		ok = 1'b0;
		case (f)
			3'h7: begin
				ok = t[2];
			end
			3'h6: begin
				ok = t[2] & ~t[0];
			end
			3'h5: begin
				ok = t[2] & ~t[1];
			end
			3'h4: begin
				ok = (t == 3'h4);
			end
			3'h3: begin
				ok = (t == 3'h3);
			end
			3'h2: begin
				ok = ~t[2] & t[1];
			end
			3'h1: begin
				ok = ~t[2] & t[0];
			end
			3'h0: begin
				ok = ~t[2];
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		scen_ok = ok;
	endfunction

	// protect register write candidate: polarity may only drop, bit 6
	// is an inert flag kept as loaded, and each size field only takes
	// the new value while its disable bit is already set, so with
	// polarity set a range can still be resized in the write that arms it
	wire [7:0] pold = protect_reg;
	logic [7:0] pcand;
	always_comb begin
		pcand = pold;
		pcand[POLARITY_BIT] = pold[POLARITY_BIT] & wb[POLARITY_BIT];
		pcand[6] = pold[6];
		pcand[HIGH_DIS_BIT] = wb[HIGH_DIS_BIT];
		pcand[LOW_DIS_BIT]  = wb[LOW_DIS_BIT];
		if (pold[HIGH_DIS_BIT])
			pcand[HIGH_SIZE_HI:HIGH_SIZE_LO] = wb[HIGH_SIZE_HI:HIGH_SIZE_LO];
		if (pold[LOW_DIS_BIT])
			pcand[LOW_SIZE_HI:LOW_SIZE_LO] = wb[LOW_SIZE_HI:LOW_SIZE_LO];
	end

	// the whole write is dropped when its scenario would remove
	// protection; no field of it lands and software sees no error,
	// so a read back is the only way to learn the write was refused
	wire [2:0] scen_from  = scen(pold);
	wire [2:0] scen_to    = scen(pcand);
	wire       prot_legal = scen_ok(scen_from, scen_to);
	assign protect_next   = (wr_prot && prot_legal) ? pcand : pold;

	// range decode: the high range always ends at the top of the map
	// and grows downward, the low range always starts at its fixed
	// base and grows upward; both bounds are inclusive, so the last
	// byte of a range is protected like the first
	wire [1:0] hs = protect_reg[HIGH_SIZE_HI:HIGH_SIZE_LO];
	wire [1:0] ls = protect_reg[LOW_SIZE_HI:LOW_SIZE_LO];
	wire [15:0] high_start = (hs == 2'h0) ? HIGH_START_0 :
		(hs == 2'h1) ? HIGH_START_1 :
		(hs == 2'h2) ? HIGH_START_2 : HIGH_START_3;
	wire [15:0] low_end = (ls == 2'h0) ? LOW_END_0 :
		(ls == 2'h1) ? LOW_END_1 :
		(ls == 2'h2) ? LOW_END_2 : LOW_END_3;
	wire in_high = (op_addr >= high_start) && (op_addr <= HIGH_RANGE_END);
	wire in_low  = (op_addr >= LOW_RANGE_BASE) && (op_addr <= low_end);
	wire pol     = protect_reg[POLARITY_BIT];
	wire hdis    = protect_reg[HIGH_DIS_BIT];
	wire ldis    = protect_reg[LOW_DIS_BIT];

	// polarity set: cleared disable protects its range; cleared
	// polarity: everything protected except ranges whose disable is clear
	// both polarities share one range match, only its sense flips;
	// a mass erase looks at no address at all, it needs the fully
	// open scenario, and until the reset load is over every op is
	// held off without raising the violation flag
	wire prot_pos = (~hdis & in_high) | (~ldis & in_low);
	wire open_neg = (~hdis & in_high) | (~ldis & in_low);
	wire addr_protected = pol ? prot_pos : ~open_neg;
	wire all_open = pol & hdis & ldis;
	wire op_bad = op_mass_erase ? ~all_open : addr_protected;
	wire op_go  = op_req & load_done;
	assign op_grant = op_go & ~op_bad;

	// read mux; the factory test slot and unmapped words read zero
	// the data is gated to the access phase of a read, so prdata sits
	// at zero between transfers instead of echoing the last register
	always_comb begin
		prdata_next = 32'h0000_0000;
		if (hit_lock)
			prdata_next[7:0] = lock_config_reg;
		else if (hit_gate)
			prdata_next[7:0] = irq_key_gate_reg;
		else if (hit_prot)
			prdata_next[7:0] = protect_reg;
		else if (hit_test)
			prdata_next[7:0] = 8'h00;
	end
	assign prdata = (acc && !pwrite) ? prdata_next : 32'h0000_0000;

	// reset loader sequence; each step waits for its own byte, and an
	// illegal state falls back to the start rather than to done, so a
	// glitch can only delay the load, never skip it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_state_reg <= LD_LOCK;
		end else begin
			case (load_state_reg)
				LD_LOCK: begin
					if (nvm_rd_valid)
						load_state_reg <= LD_PROT;
				end
				LD_PROT: begin
					if (nvm_rd_valid)
						load_state_reg <= LD_DONE;
				end
				LD_DONE: begin
					load_state_reg <= LD_DONE;
				end
				default: begin
					load_state_reg <= LD_LOCK;
				end
			endcase
		end
	end

	// lock register: no bus write path at all, backdoor forces unlocked
	// the reset value reads as locked with the backdoor shut, so the
	// part is safe even before the loader has fetched the real byte;
	// an unlock only touches the state field, the flags stay as loaded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_config_reg <= 8'h00;
		end else if (load_state_reg == LD_LOCK && nvm_rd_valid) begin
			lock_config_reg <= nvm_rd_data;
		end else if (load_done && backdoor_unlock && backdoor_allowed) begin
			lock_config_reg[LOCK_STATE_HI:LOCK_STATE_LO] <= LOCK_UNLOCKED;
		end
	end

	// control register; reset leaves both interrupts off and the key
	// gate shut, so array writes start out as plain commands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_key_gate_reg <= IRQ_KEY_GATE_RESET;
		else
			irq_key_gate_reg <= irq_key_gate_next;
	end

	// protect register; the loaded byte wins over any bus write in the
	// same cycle, and the reset value only stands until that byte
	// arrives, while every op is refused anyway
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			protect_reg <= 8'h00;
		else if (load_state_reg == LD_PROT && nvm_rd_valid)
			protect_reg <= nvm_rd_data;
		else
			protect_reg <= protect_next;
	end

	// violation flag: refused op sets it, cleared by the grant
	// of a fresh legal op; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			protect_violation_flag <= 1'b0;
		else if (op_go && op_bad)
			protect_violation_flag <= 1'b1;
		else if (op_grant)
			protect_violation_flag <= 1'b0;
	end
endmodule
`default_nettype wire

// File: tb/flash_lock_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module flash_lock_checker import flash_lock_pkg::*; (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        load_done,
	input wire logic        backdoor_unlock,
	input wire logic        buffer_empty_flag,
	input wire logic        cmd_done_flag,
	input wire logic        flash_irq,
	input wire logic        unlocked,
	input wire logic        backdoor_allowed,
	input wire logic        key_write_gate,
	input wire logic        array_read_invalid,
	input wire logic        op_req,
	input wire logic        op_grant,
	input wire logic        protect_violation_flag
);
	// access-phase decode; reads before loading are left unjudged
	wire logic rd = psel && penable && !pwrite && load_done;
	wire logic wr = psel && penable && pwrite && load_done;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_UNLOCK_CODE: assert property (rd && paddr == ADDR_LOCK_CONFIG |->
		(prdata[1:0] == 2'h2) == unlocked) else $error("lock state mismatch");
	AST_BACKDOOR_CODE: assert property (rd && paddr == ADDR_LOCK_CONFIG |->
		(prdata[7:6] == 2'h2) == backdoor_allowed) else $error("enable mismatch");
	AST_LOCK_RO: assert property (wr && paddr == ADDR_LOCK_CONFIG
		&& !backdoor_unlock |=> $stable(unlocked) && $stable(backdoor_allowed))
		else $error("lock register changed by write");
	AST_TEST_ZERO: assert property (rd && paddr == ADDR_FACTORY_TEST
		|-> prdata == 32'h0) else $error("factory slot not zero");
	AST_CFG_BITS: assert property (rd && paddr == ADDR_IRQ_KEY_GATE |->
		prdata[4:0] == 5'h0 && prdata[5] == key_write_gate)
		else $error("config bits wrong");
	AST_GATE_HELD: assert property (!backdoor_allowed && load_done
		|=> $stable(key_write_gate)) else $error("key gate changed");
	AST_GATE_ROUTE: assert property (array_read_invalid == key_write_gate)
		else $error("array read invalid mismatch");
	AST_IRQ_QUIET: assert property (!buffer_empty_flag && !cmd_done_flag
		|-> !flash_irq) else $error("irq without source");
	AST_UNLOCK_PULSE: assert property (backdoor_unlock && backdoor_allowed
		&& load_done |=> unlocked) else $error("backdoor unlock lost");
	AST_VIOLATION: assert property (op_req && load_done && !op_grant
		|=> protect_violation_flag) else $error("violation not flagged");
endmodule
bind flash_lock_and_protect_regs flash_lock_checker chk (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .prdata, .load_done, .backdoor_unlock,
	.buffer_empty_flag, .cmd_done_flag, .flash_irq, .unlocked,
	.backdoor_allowed, .key_write_gate, .array_read_invalid, .op_req,
	.op_grant, .protect_violation_flag);
`default_nettype wire

// File: tb/flash_byte_source.sv
`timescale 1ns/1ps
`default_nettype none
module flash_byte_source import flash_lock_pkg::*; #(
	parameter logic [7:0] LOCK_BYTE = 8'h95,
	parameter logic [7:0] PROT_BYTE = 8'h8F
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        nvm_rd_req,
	input  wire logic [15:0] nvm_rd_addr,
	output logic      [7:0]  nvm_rd_data,
	output logic             nvm_rd_valid
);
	logic [1:0] wait_cnt;
	// slow array: four cycles per byte; data toggles when not valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt     <= 2'h0;
			nvm_rd_valid <= 1'h0;
			nvm_rd_data  <= 8'h00;
		end else begin
			nvm_rd_valid <= 1'h0;
			nvm_rd_data  <= ~nvm_rd_data;
			if (nvm_rd_req && !nvm_rd_valid) begin
				wait_cnt <= wait_cnt + 2'h1;
				if (wait_cnt == 2'h3) begin
					nvm_rd_valid <= 1'h1;
					nvm_rd_data  <= (nvm_rd_addr == LOCK_LOAD_ADDR) ?
						LOCK_BYTE : PROT_BYTE;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/flash_lock_and_protect_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_lock_and_protect_regs_tb;
	import flash_lock_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, nvm_rd_valid;
	logic        load_done, backdoor_unlock, buffer_empty_flag, cmd_done_flag;
	logic        flash_irq, unlocked, backdoor_allowed, key_write_gate;
	logic        array_read_invalid, op_req, op_mass_erase, op_grant;
	logic        protect_violation_flag, pready, pslverr, nvm_rd_req, err;
	logic [3:0]  pstrb;
	logic [7:0]  nvm_rd_data;
	logic [11:0] paddr;
	logic [15:0] op_addr, nvm_rd_addr;
	logic [31:0] pwdata, prdata, r;
	int          num_errors, checks_done, cyc;
	flash_lock_and_protect_regs dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.nvm_rd_req, .nvm_rd_addr, .nvm_rd_data, .nvm_rd_valid, .load_done,
		.backdoor_unlock, .buffer_empty_flag, .cmd_done_flag, .flash_irq,
		.unlocked, .backdoor_allowed, .key_write_gate, .array_read_invalid,
		.op_req, .op_mass_erase, .op_addr, .op_grant, .protect_violation_flag);
	flash_byte_source flash (.pclk, .presetn, .nvm_rd_req, .nvm_rd_addr,
		.nvm_rd_data, .nvm_rd_valid);
	task automatic end_sim;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// program/erase request; grant seen same cycle, flag one edge later
	task automatic op(input logic m, input logic [15:0] a, input logic g);
		@(posedge pclk);
		op_req <= 1'h1; op_mass_erase <= m; op_addr <= a;
		@(negedge pclk);
		cmp(op_grant, g);
		@(posedge pclk);
		op_req <= 1'h0;
		@(negedge pclk);
		cmp(protect_violation_flag, !g);
	endtask
	task automatic t_lock;
		apb(1'h0, ADDR_LOCK_CONFIG, 32'h0);
		cmp(r, 32'h95);
		apb(1'h1, ADDR_LOCK_CONFIG, 32'h0);
		apb(1'h0, ADDR_LOCK_CONFIG, 32'h0);
		cmp(r, 32'h95);
		cmp(unlocked, 1'h0);
		cmp(backdoor_allowed, 1'h1);
		apb(1'h1, ADDR_FACTORY_TEST, 32'hFF);
		apb(1'h0, ADDR_FACTORY_TEST, 32'h0);
		cmp(r, 32'h0);
		apb(1'h0, 12'h020, 32'h0);
		cmp(err, 1'h1);
	endtask
	// each enable alone against all four flag combinations
	task automatic t_cfg;
		apb(1'h1, ADDR_IRQ_KEY_GATE, 32'hFF);
		apb(1'h0, ADDR_IRQ_KEY_GATE, 32'h0);
		cmp(r, 32'hE0);
		cmp(array_read_invalid, 1'h1);
		for (int k = 0; k < 2; k++) begin
			apb(1'h1, ADDR_IRQ_KEY_GATE, k ? 32'h80 : 32'h40);
			for (int i = 0; i < 4; i++) begin
				@(posedge pclk);
				buffer_empty_flag <= i[0];
				cmd_done_flag <= i[1];
				@(negedge pclk);
				cmp(flash_irq, k ? i[0] : i[1]);
			end
		end
		cmp(key_write_gate, 1'h0);
	endtask
	task automatic t_unlock;
		@(posedge pclk);
		backdoor_unlock <= 1'h1;
		@(posedge pclk);
		backdoor_unlock <= 1'h0;
		apb(1'h0, ADDR_LOCK_CONFIG, 32'h0);
		cmp(r, 32'h96);
		cmp(unlocked, 1'h1);
	endtask
	// loaded scenario: high range F000-FFFF protected, low open
	task automatic t_prot;
		apb(1'h0, ADDR_PROTECT, 32'h0);
		cmp(r, 32'h8F);
		op(1'h0, 16'hF000, 1'h0);
		op(1'h0, 16'hEFFF, 1'h1);
		op(1'h0, 16'h5FFF, 1'h1);
		op(1'h1, 16'h0000, 1'h0);
		apb(1'h1, ADDR_PROTECT, 32'h9F);
		apb(1'h0, ADDR_PROTECT, 32'h0);
		cmp(r, 32'h8F);
		apb(1'h1, ADDR_PROTECT, 32'h0F);
		apb(1'h0, ADDR_PROTECT, 32'h0);
		cmp(r, 32'h8F);
		apb(1'h1, ADDR_PROTECT, 32'h8B);
		apb(1'h0, ADDR_PROTECT, 32'h0);
		cmp(r, 32'h8B);
		op(1'h0, 16'h5FFF, 1'h0);
		op(1'h0, PROTECT_LOAD_ADDR, 1'h0);
		op(1'h0, 16'h6000, 1'h1);
		apb(1'h1, ADDR_PROTECT, 32'h8F);
		apb(1'h0, ADDR_PROTECT, 32'h0);
		cmp(r, 32'h8B);
	endtask
	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end
	// hang guard, well above the roughly 120 cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			end_sim();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, op_req, op_mass_erase} = 6'h0;
		{backdoor_unlock, buffer_empty_flag, cmd_done_flag} = 3'h0;
		{paddr, pwdata, op_addr} = 60'h0;
		pstrb = 4'hF;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		while (load_done !== 1'h1) @(posedge pclk);
		t_lock();
		t_cfg();
		t_prot();
		t_unlock();
		end_sim();
	end
endmodule
`default_nettype wire
